// ===== core_data_memory_organization.sv
`timescale 1ns/1ps
// Operation
// (RULE1) Relative branch adds signed 8-bit offset to next instruction address.
// (RULE2) Direct addresses below 0x80 hit RAM, others hit special registers.
// (RULE3) Page-local target replaces low 11 bits, staying in 2K page.
// (RULE4) Long target reaches anywhere in 64K program space.
// (RULE5) Opcode 0xA5 behaves exactly like no-operation.
// (RULE6) Instruction type alone chooses program or data space.
// (RULE7) Program store writes only when write-enable bit is set.
// (RULE8) Lower 128 bytes reachable directly and indirectly.
// (RULE9) Indirect above 0x7F hits separate upper RAM, never special registers.
// (RULE10) Bytes 0x00-0x1F form four banks of eight registers.
// (RULE11) Status word bits 3 and 4 pick the single active bank.
// (RULE12) Indirect pointer is only R0 or R1 of active bank.
// (RULE13) Bytes 0x20-0x2F give bits 0x00-0x7F, bit address 8k+n.
// (RULE14) Operand type, not address, chooses bit or byte access.
// (RULE15) Push writes pointer plus one, then increments pointer.
// (RULE16) Stack pointer at 0x81 resets to 0x07.
// (RULE17) Stack record gains/loses one bit per push/pop, two per call/return.
// (RULE18) Stack record overflow and underflow reported to debug.
// (RULE19) Special registers at addresses ending 0 or 8 are bit addressable.
// (RULE20) Software must avoid unoccupied special register addresses.
// (RULE21) Bit addresses 0x80-0xFF pick bits of bit-addressable special registers.
module core_data_memory_organization
#(
   parameter int RECORD_DEPTH = core_mem_pkg::STACK_RECORD_BITS
) (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire core_mem_pkg::access_kind_t i_access_kind,
   input wire logic i_access_write,
   input wire logic [7:0] i_access_addr,
   input wire logic [7:0] i_access_wdata,
   input wire logic i_bit_wdata,
   input wire core_mem_pkg::stack_op_t i_stack_op,
   input wire logic [7:0] i_stack_wdata,
   input wire logic [7:0] i_sfr_rdata,
   input wire logic i_branch_valid,
   input wire core_mem_pkg::branch_kind_t i_branch_kind,
   input wire logic [15:0] i_next_pc,
   input wire logic [15:0] i_branch_operand,
   input wire logic [7:0] i_opcode,
   input wire logic i_external_data_move,
   input wire logic [15:0] i_external_addr,
   output logic [7:0] o_access_rdata,
   output logic o_bit_rdata,
   output logic o_access_ack,
   output logic o_bit_refused,
   output logic [7:0] o_stack_rdata,
   output logic o_sfr_write,
   output logic o_sfr_read,
   output logic [7:0] o_sfr_addr,
   output logic [7:0] o_sfr_wdata,
   output logic o_sfr_bit_access,
   output logic [2:0] o_sfr_bit_pos,
   output logic o_sfr_bit_wdata,
   output logic [15:0] o_branch_target,
   output logic o_branch_target_valid,
   output logic [7:0] o_opcode_exec,
   output logic o_program_store_write,
   output logic [15:0] o_program_store_addr,
   output logic [7:0] o_program_store_wdata,
   output logic [7:0] O_STACK_TOP_POINTER,
   output logic [1:0] O_ACTIVE_BANK,
   output logic O_STACK_RECORD_OVERFLOW,
   output logic O_STACK_RECORD_UNDERFLOW
);
   import core_mem_pkg::*;

   if (RECORD_DEPTH < 2 || RECORD_DEPTH > 255) begin : g_depth_check
      $error("record depth out of range");
   end

   // --------------------
   // Storage
   // --------------------
   // Lower and upper RAM are separate arrays so that no address overlap
   // can ever let an indirect access land in the special registers.
   logic [7:0] lower_ram [0:127];
   logic [7:0] upper_ram [0:127];
   logic [7:0] stack_top_pointer_reg;
   logic [7:0] program_status_word_reg;
   logic [7:0] program_store_control_reg;

   // --------------------
   // Address decode
   // --------------------
   logic [1:0] bank_w;
   logic is_direct_w;
   logic is_indirect_w;
   logic is_register_w;
   logic is_bit_w;
   logic [7:0] reg_addr_w;
   logic [7:0] pointer_w;
   logic [7:0] byte_addr_w;
   logic to_sfr_w;
   logic to_upper_w;
   logic [7:0] bit_byte_w;
   logic [2:0] bit_pos_w;
   logic bit_sfr_w;
   logic sfr_bit_ok_w;
   logic local_sfr_w;
   logic [7:0] local_sfr_rdata_w;
   logic [7:0] ram_rdata_w;
   logic [7:0] byte_rdata_w;

   assign bank_w = {program_status_word_reg[BANK_SELECT_HIGH_POS],
                    program_status_word_reg[BANK_SELECT_LOW_POS]}; // (RULE11)
   assign is_direct_w = i_access_kind == ACC_DIRECT;
   assign is_indirect_w = i_access_kind == ACC_INDIRECT;
   assign is_register_w = i_access_kind == ACC_REGISTER;
   assign is_bit_w = i_access_kind == ACC_BIT; // (RULE14)
   // Register operands live only in the active bank.
   assign reg_addr_w = {3'h0, bank_w, i_access_addr[2:0]}; // (RULE10)
   // The pointer register is R0 or R1 of the active bank.
   assign pointer_w = lower_ram[{2'h0, bank_w, 2'h0, i_access_addr[0]}]; // (RULE12)
   assign byte_addr_w = is_indirect_w ? pointer_w :
                        is_register_w ? reg_addr_w : i_access_addr;
   assign to_sfr_w = is_direct_w && i_access_addr[7]; // (RULE2)
   assign to_upper_w = is_indirect_w && pointer_w[7]; // (RULE9)
   // Bit address 8k+n maps to byte 0x20+k in RAM, or register k*8 above.
   assign bit_sfr_w = i_access_addr[7]; // (RULE21)
   assign bit_byte_w = bit_sfr_w ? {i_access_addr[7:3], 3'h0} :
                       BIT_RAM_BASE + {4'h0, i_access_addr[6:3]}; // (RULE13)
   assign bit_pos_w = i_access_addr[2:0];
   // Only addresses ending 0 or 8 decode as bit-addressable registers.
   assign sfr_bit_ok_w = bit_byte_w[2:0] == 3'h0; // (RULE19)
   assign local_sfr_w = (is_direct_w && (i_access_addr == STACK_TOP_POINTER_ADDR ||
                         i_access_addr == PROGRAM_STATUS_WORD_ADDR ||
                         i_access_addr == PROGRAM_STORE_CONTROL_ADDR)) ||
                        (is_bit_w && bit_sfr_w &&
                         bit_byte_w == PROGRAM_STATUS_WORD_ADDR);
   assign local_sfr_rdata_w =
      (is_bit_w || i_access_addr == PROGRAM_STATUS_WORD_ADDR) ? program_status_word_reg :
      i_access_addr == STACK_TOP_POINTER_ADDR ? stack_top_pointer_reg :
      program_store_control_reg;
   assign ram_rdata_w = to_upper_w ? upper_ram[pointer_w[6:0]] :
                        is_bit_w ? lower_ram[bit_byte_w[6:0]] :
                        lower_ram[byte_addr_w[6:0]]; // (RULE8)
   assign byte_rdata_w = local_sfr_w ? local_sfr_rdata_w :
                         (to_sfr_w || (is_bit_w && bit_sfr_w)) ? i_sfr_rdata :
                         ram_rdata_w;

   // --------------------
   // Stack pointer arithmetic
   // --------------------
   logic [7:0] sp_plus1_w;
   logic [7:0] sp_minus1_w;
   logic [7:0] sp_next;
   logic stack_write_w;
   logic [7:0] stack_waddr_w;
   logic sp_direct_write_w;

   assign sp_plus1_w = stack_top_pointer_reg + 8'h01;
   assign sp_minus1_w = stack_top_pointer_reg - 8'h01;
   // A call writes one byte per cycle and steps the pointer by one, like a push.
   assign stack_write_w = i_stack_op == STK_PUSH || i_stack_op == STK_CALL;
   assign stack_waddr_w = sp_plus1_w; // (RULE15)
   assign sp_direct_write_w = is_direct_w && i_access_write &&
                              i_access_addr == STACK_TOP_POINTER_ADDR;
   assign sp_next = sp_direct_write_w ? i_access_wdata :
                    stack_write_w ? sp_plus1_w : // (RULE15)
                    i_stack_op == STK_POP ? sp_minus1_w :
                    i_stack_op == STK_RETURN ? sp_minus1_w :
                    stack_top_pointer_reg;

   // --------------------
   // Stack record
   // --------------------
   // A direct write that moves the pointer by one counts as inc or dec.
   logic [1:0] grow_w;
   logic [1:0] shrink_w;
   logic sp_inc_w;
   logic sp_dec_w;

   assign sp_inc_w = sp_direct_write_w && i_access_wdata == sp_plus1_w;
   assign sp_dec_w = sp_direct_write_w && i_access_wdata == sp_minus1_w;
   // Calls and returns are reported once per instruction, worth two bits.
   assign grow_w = i_stack_op == STK_CALL ? 2'h2 :
                   (i_stack_op == STK_PUSH || sp_inc_w) ? 2'h1 : 2'h0; // (RULE17)
   assign shrink_w = i_stack_op == STK_RETURN ? 2'h2 :
                     (i_stack_op == STK_POP || sp_dec_w) ? 2'h1 : 2'h0; // (RULE17)

   logic record_over_w;
   logic record_under_w;

   stack_record #(
      .DEPTH(RECORD_DEPTH)
   ) u_record (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_grow(grow_w),
      .i_shrink(shrink_w),
      .o_fill(),
      .o_overflow(record_over_w),
      .o_underflow(record_under_w)
   ); // (RULE18)

   // --------------------
   // Branch targets and opcode aliasing
   // --------------------
   logic [15:0] rel_target_w;
   logic [15:0] page_target_w;
   logic [15:0] branch_target_w;
   logic [7:0] opcode_w;

   assign rel_target_w = i_next_pc + {{8{i_branch_operand[7]}}, i_branch_operand[7:0]}; // (RULE1)
   assign page_target_w = {i_next_pc[15:PAGE_LOCAL_BITS],
                           i_branch_operand[PAGE_LOCAL_BITS-1:0]}; // (RULE3)
   assign branch_target_w = i_branch_kind == BR_RELATIVE ? rel_target_w :
                            i_branch_kind == BR_PAGE_LOCAL ? page_target_w :
                            i_branch_operand; // (RULE4)
   assign opcode_w = i_opcode == NOP_ALIAS_OPCODE ? NOP_OPCODE : i_opcode; // (RULE5)

   // --------------------
   // Program store path
   // --------------------
   // External moves go to program memory only with the enable bit set;
   // the data space itself is never touched by that path.
   logic ps_write_w;
   assign ps_write_w = i_external_data_move &&
                       program_store_control_reg[PROGRAM_STORE_WRITE_POS]; // (RULE7) (RULE6)

   // --------------------
   // Write enables
   // --------------------
   logic ram_write_w;
   logic upper_write_w;
   logic [7:0] bit_merged_w;
   logic sfr_out_write_w;
   logic sfr_out_read_w;

   assign bit_merged_w = (byte_rdata_w & ~(8'h01 << bit_pos_w)) |
                         ({7'h00, i_bit_wdata} << bit_pos_w);
   assign ram_write_w = i_access_write && !to_sfr_w && !to_upper_w &&
      (is_direct_w || is_indirect_w || is_register_w || (is_bit_w && !bit_sfr_w));
   assign upper_write_w = i_access_write && to_upper_w; // (RULE9)
   // Unoccupied register addresses are passed out unchanged; their effect
   // belongs to software to avoid.
   assign sfr_out_write_w = i_access_write && !local_sfr_w &&
      (to_sfr_w || (is_bit_w && bit_sfr_w && sfr_bit_ok_w)); // (RULE20)
   assign sfr_out_read_w = !i_access_write && !local_sfr_w &&
      (to_sfr_w || (is_bit_w && bit_sfr_w && sfr_bit_ok_w));

   // --------------------
   // Memory arrays (no reset; contents are undefined after power-up)
   // --------------------
   always_ff @(posedge I_CLK) begin
      if (ram_write_w) begin
         lower_ram[is_bit_w ? bit_byte_w[6:0] : byte_addr_w[6:0]] <=
            is_bit_w ? bit_merged_w : i_access_wdata; // (RULE8) (RULE13)
      end
      if (stack_write_w && !stack_waddr_w[7]) begin
         lower_ram[stack_waddr_w[6:0]] <= i_stack_wdata; // (RULE15)
      end
   end

   // The stack lives in the whole 256-byte space, so high pushes go to
   // the upper RAM exactly like indirect accesses do.
   always_ff @(posedge I_CLK) begin
      if (upper_write_w) begin
         upper_ram[pointer_w[6:0]] <= i_access_wdata;
      end
      if (stack_write_w && stack_waddr_w[7]) begin
         upper_ram[stack_waddr_w[6:0]] <= i_stack_wdata;
      end
   end

   // --------------------
   // Locally held special registers
   // --------------------
   logic [7:0] psw_next;
   logic [7:0] program_store_control_next;
   assign psw_next = (is_bit_w && bit_sfr_w && bit_byte_w == PROGRAM_STATUS_WORD_ADDR &&
                      i_access_write) ? bit_merged_w :
                     (is_direct_w && i_access_write &&
                      i_access_addr == PROGRAM_STATUS_WORD_ADDR) ? i_access_wdata :
                     program_status_word_reg;
   assign program_store_control_next = (is_direct_w && i_access_write &&
                        i_access_addr == PROGRAM_STORE_CONTROL_ADDR) ? i_access_wdata :
                       program_store_control_reg;

   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         stack_top_pointer_reg <= STACK_TOP_POINTER_RESET; // (RULE16)
         program_status_word_reg <= 8'h00;
         program_store_control_reg <= 8'h00;
      end else begin
         stack_top_pointer_reg <= sp_next;
         program_status_word_reg <= psw_next;
         program_store_control_reg <= program_store_control_next;
      end
   end

   // --------------------
   // Registered outputs
   // --------------------
   always_ff @(posedge I_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         o_access_rdata <= 8'h00;
         o_bit_rdata <= 1'b0;
         o_access_ack <= 1'b0;
         o_bit_refused <= 1'b0;
         o_stack_rdata <= 8'h00;
         o_sfr_write <= 1'b0;
         o_sfr_read <= 1'b0;
         o_sfr_addr <= 8'h00;
         o_sfr_wdata <= 8'h00;
         o_sfr_bit_access <= 1'b0;
         o_sfr_bit_pos <= 3'h0;
         o_sfr_bit_wdata <= 1'b0;
         o_branch_target <= 16'h0000;
         o_branch_target_valid <= 1'b0;
         o_opcode_exec <= 8'h00;
         o_program_store_write <= 1'b0;
         o_program_store_addr <= 16'h0000;
         o_program_store_wdata <= 8'h00;
      end else begin
         o_access_rdata <= byte_rdata_w;
         o_bit_rdata <= byte_rdata_w[bit_pos_w];
         o_access_ack <= i_access_kind != ACC_NONE;
         o_bit_refused <= is_bit_w && bit_sfr_w && !sfr_bit_ok_w; // (RULE19)
         o_stack_rdata <= stack_top_pointer_reg[7] ?
            upper_ram[stack_top_pointer_reg[6:0]] : lower_ram[stack_top_pointer_reg[6:0]];
         o_sfr_write <= sfr_out_write_w;
         o_sfr_read <= sfr_out_read_w;
         o_sfr_addr <= is_bit_w ? bit_byte_w : i_access_addr;
         o_sfr_wdata <= i_access_wdata;
         o_sfr_bit_access <= is_bit_w;
         o_sfr_bit_pos <= bit_pos_w;
         o_sfr_bit_wdata <= i_bit_wdata;
         o_branch_target <= branch_target_w;
         o_branch_target_valid <= i_branch_valid;
         o_opcode_exec <= opcode_w;
         o_program_store_write <= ps_write_w && i_access_write;
         o_program_store_addr <= i_external_addr;
         o_program_store_wdata <= i_access_wdata;
      end
   end

   // Status outputs mirror flops directly.
   assign O_STACK_TOP_POINTER = stack_top_pointer_reg;
   assign O_ACTIVE_BANK = bank_w;
   assign O_STACK_RECORD_OVERFLOW = record_over_w;
   assign O_STACK_RECORD_UNDERFLOW = record_under_w;
endmodule // core_data_memory_organization

// ===== core_mem_pkg.sv
package core_mem_pkg;
   // Address map boundaries and field positions.
   localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam logic [7:0] STACK_TOP_POINTER_ADDR = 8'h81;
   localparam logic [7:0] STACK_TOP_POINTER_RESET = 8'h07;
   localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hD0;
   localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8F;
   localparam int BANK_SELECT_LOW_POS = 3;
   localparam int BANK_SELECT_HIGH_POS = 4;
   localparam int PROGRAM_STORE_WRITE_POS = 0;
   localparam logic [7:0] NOP_ALIAS_OPCODE = 8'hA5;
   localparam logic [7:0] NOP_OPCODE = 8'h00;
   localparam int STACK_RECORD_BITS = 32;
   localparam int PAGE_LOCAL_BITS = 11;

   // Kind of data access requested by the execution unit.
   typedef enum logic [2:0] {
      ACC_NONE = 3'h0,
      ACC_DIRECT = 3'h1,
      ACC_INDIRECT = 3'h2,
      ACC_REGISTER = 3'h3,
      ACC_BIT = 3'h4
   } access_kind_t;

   // Stack-affecting operation reported by the execution unit.
   typedef enum logic [2:0] {
      STK_NONE = 3'h0,
      STK_PUSH = 3'h1,
      STK_POP = 3'h2,
      STK_CALL = 3'h3,
      STK_RETURN = 3'h4
   } stack_op_t;

   // Branch target kinds.
   typedef enum logic [1:0] {
      BR_RELATIVE = 2'h0,
      BR_PAGE_LOCAL = 2'h1,
      BR_LONG = 2'h2
   } branch_kind_t;
endpackage

// ===== stack_record.sv
`timescale 1ns/1ps
module stack_record #(
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [1:0] i_grow,
   input wire logic [1:0] i_shrink,
   output logic [$clog2(DEPTH+1)-1:0] o_fill,
   output logic o_overflow,
   output logic o_underflow
);
   localparam int FW = $clog2(DEPTH + 1);
   localparam logic [FW-1:0] FULL = FW'(DEPTH);

   if (DEPTH < 2) begin : g_depth_check
      $error("stack_record depth must be at least two");
   end

   logic [FW-1:0] fill_reg;
   logic [FW-1:0] fill_next;
   logic [FW:0] sum_w;
   logic over_w;
   logic under_w;

   // --------------------
   // Occupancy tracking
   // --------------------
   // Only the fill level matters for overflow detection, so the record
   // contents themselves are not stored; this saves the 32 flops.
   assign sum_w = {1'b0, fill_reg} + {{(FW-1){1'b0}}, i_grow};
   assign over_w = sum_w > {1'b0, FULL} + {{(FW-1){1'b0}}, i_shrink}; // (RULE18)
   assign under_w = sum_w < {{(FW-1){1'b0}}, i_shrink}; // (RULE18)
   assign fill_next = over_w ? FULL : under_w ? '0 :
      FW'(sum_w - {{(FW-1){1'b0}}, i_shrink}); // (RULE17)

   // Flags are sticky until reset so debug software cannot miss them.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fill_reg <= '0;
         o_overflow <= 1'b0;
         o_underflow <= 1'b0;
      end else begin
         fill_reg <= fill_next;
         o_overflow <= o_overflow | over_w;
         o_underflow <= o_underflow | under_w;
      end
   end

   assign o_fill = fill_reg;
endmodule // stack_record

// ===== sfr_space_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------
// Special register space seen from the far side of the block.
// -----------------------------------------------------------
module sfr_space_model (
   input wire logic i_clk,
   input wire logic i_write,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_read_addr,
   output logic [7:0] o_rdata
);
   logic [7:0] regs [256];

   // Registers start cleared so that a forwarded read has a known answer.
   initial begin
      foreach (regs[i]) regs[i] = 8'h00;
   end

   // Writes land on the edge that carries the forwarded pulse.
   always @(posedge i_clk) begin
      if (i_write) regs[i_addr] <= i_wdata;
   end

   // Reads answer in the same cycle, as the execution unit expects.
   assign o_rdata = regs[i_read_addr];
endmodule // sfr_space_model

// ===== core_mem_chk.sv
`timescale 1ns/1ps
// -----------------------------------------------------------
// Port-level checks for the data memory organisation block.
// -----------------------------------------------------------
module core_mem_chk
   import core_mem_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire core_mem_pkg::access_kind_t i_access_kind,
   input wire logic i_access_write,
   input wire logic [7:0] i_access_addr,
   input wire logic [7:0] i_access_wdata,
   input wire core_mem_pkg::stack_op_t i_stack_op,
   input wire logic i_branch_valid,
   input wire core_mem_pkg::branch_kind_t i_branch_kind,
   input wire logic [15:0] i_next_pc,
   input wire logic [15:0] i_branch_operand,
   input wire logic [7:0] i_opcode,
   input wire logic o_access_ack,
   input wire logic o_sfr_write,
   input wire logic o_sfr_read,
   input wire logic [15:0] o_branch_target,
   input wire logic [7:0] o_opcode_exec,
   input wire logic [7:0] O_STACK_TOP_POINTER,
   input wire logic [1:0] O_ACTIVE_BANK,
   input wire logic O_STACK_RECORD_OVERFLOW
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   // Expected targets worked out at request time, compared one cycle on.
   wire [15:0] rel_target = i_next_pc + {{8{i_branch_operand[7]}}, i_branch_operand[7:0]};
   wire [15:0] page_target = {i_next_pc[15:11], i_branch_operand[10:0]};
   wire is_rel = i_branch_valid && i_branch_kind == BR_RELATIVE;
   wire is_page = i_branch_valid && i_branch_kind == BR_PAGE_LOCAL;
   wire quiet = i_access_kind == ACC_NONE;

   // A status word write is a two-step behaviour: request, then new bank.
   sequence psw_write_s;
      i_access_kind == ACC_DIRECT && i_access_write && i_access_addr == 8'hD0;
   endsequence

   reset_pointer_a: assert property ($fell(I_RESET) |-> O_STACK_TOP_POINTER == 8'h07)
      else $error("pointer not at its reset value");
   push_step_a: assert property (i_stack_op == STK_PUSH && quiet |=>
      O_STACK_TOP_POINTER == $past(O_STACK_TOP_POINTER) + 8'h01)
      else $error("push did not step the pointer up by one");
   pop_step_a: assert property (i_stack_op == STK_POP && quiet |=>
      O_STACK_TOP_POINTER == $past(O_STACK_TOP_POINTER) - 8'h01)
      else $error("pop did not step the pointer down by one");
   bank_select_a: assert property (psw_write_s |=> O_ACTIVE_BANK == $past(i_access_wdata[4:3]))
      else $error("active bank does not follow the status word");
   nop_alias_a: assert property (i_opcode == 8'hA5 |=> o_opcode_exec == 8'h00)
      else $error("alias opcode not turned into no-operation");
   relative_target_a: assert property (is_rel |=> o_branch_target == $past(rel_target))
      else $error("relative branch target wrong");
   page_target_a: assert property (is_page |=> o_branch_target == $past(page_target))
      else $error("page-local target left its page");
   indirect_no_sfr_a: assert property (i_access_kind == ACC_INDIRECT |=>
      !o_sfr_read && !o_sfr_write && o_access_ack)
      else $error("indirect access reached the special registers");
   record_sticky_a: assert property (O_STACK_RECORD_OVERFLOW |=> O_STACK_RECORD_OVERFLOW)
      else $error("overflow flag dropped without reset");
endmodule // core_mem_chk

// ===== core_data_memory_organization_tb.sv
`timescale 1ns/1ps
bind core_data_memory_organization core_mem_chk chk (.*);

module core_data_memory_organization_tb;
   import core_mem_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, bitw = 1'b0, bv = 1'b0, xm = 1'b0;
   access_kind_t kind = ACC_NONE;
   stack_op_t sop = STK_NONE;
   branch_kind_t bk = BR_RELATIVE;
   logic [7:0] addr = 8'h00, wdata = 8'h00, sdat = 8'h00, opc = 8'h00, srd, rdata, sfr_addr;
   logic [7:0] sfr_wd, opx, pdata, sp, stop;
   logic [15:0] npc = 16'h0000, bop = 16'h0000, xa = 16'h0000, btgt, paddr;
   logic bitr, ack, sfr_rd, sfr_wr, sbit, spbit, pw, ovf, unf, btv;
   logic [2:0] sbpos;
   logic [1:0] bank;
   int n_errors = 0, tests_run = 0;

   // Free-running system clock, 10 ns period.
   always #5 clk = ~clk;

   core_data_memory_organization #(.RECORD_DEPTH(32)) dut (.I_CLK(clk), .I_RESET(rst),
      .i_access_kind(kind), .i_access_write(wr), .i_access_addr(addr), .i_access_wdata(wdata),
      .i_bit_wdata(bitw), .i_stack_op(sop), .i_stack_wdata(sdat), .i_sfr_rdata(srd),
      .i_branch_valid(bv), .i_branch_kind(bk), .i_next_pc(npc), .i_branch_operand(bop),
      .i_opcode(opc), .i_external_data_move(xm), .i_external_addr(xa), .o_access_rdata(rdata),
      .o_bit_rdata(bitr), .o_access_ack(ack), .o_bit_refused(), .o_stack_rdata(stop),
      .o_sfr_write(sfr_wr), .o_sfr_read(sfr_rd), .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wd),
      .o_sfr_bit_access(sbit), .o_sfr_bit_pos(sbpos), .o_sfr_bit_wdata(spbit),
      .o_branch_target(btgt), .o_branch_target_valid(btv), .o_opcode_exec(opx),
      .o_program_store_write(pw), .o_program_store_addr(paddr), .o_program_store_wdata(pdata),
      .O_STACK_TOP_POINTER(sp), .O_ACTIVE_BANK(bank), .O_STACK_RECORD_OVERFLOW(ovf),
      .O_STACK_RECORD_UNDERFLOW(unf));

   sfr_space_model far (.i_clk(clk), .i_write(sfr_wr), .i_addr(sfr_addr), .i_wdata(sfr_wd),
      .i_read_addr(addr), .o_rdata(srd));

   // -----------------------------------------------------------
   // Shared tasks.
   // -----------------------------------------------------------
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Every request is held for one edge and answers just after that same edge.
   task automatic acc(input access_kind_t k, input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      kind <= k;
      wr <= w;
      addr <= a;
      wdata <= d;
      bitw <= d[0];
      @(posedge clk);
      kind <= ACC_NONE;
      wr <= 1'b0;
      #1;
   endtask

   task automatic stk(input stack_op_t op);
      @(posedge clk);
      sop <= op;
      sdat <= 8'hAB;
      @(posedge clk);
      sop <= STK_NONE;
      #1;
   endtask

   // Branch, opcode and external move share one request cycle.
   task automatic misc(input logic b, input branch_kind_t k, input logic [15:0] pc,
                       input logic [15:0] op, input logic [7:0] code, input logic x);
      @(posedge clk);
      bv <= b;
      bk <= k;
      npc <= pc;
      bop <= op;
      opc <= code;
      xm <= x;
      wr <= x;
      xa <= 16'h1234;
      wdata <= 8'h5C;
      @(posedge clk);
      bv <= 1'b0;
      xm <= 1'b0;
      wr <= 1'b0;
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Cuts a hang short; the sequence needs about 130 cycles.
   initial begin
      #20000;
      n_errors++;
      tally_and_finish();
   end

   // -----------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------
   initial begin
      do_reset();
      #1;
      check_val(16'(sp), 16'h0007);
      for (int b = 0; b < 4; b++) acc(ACC_DIRECT, 1'b1, 8'(8 * b), 8'(8'h40 + b));
      for (int b = 0; b < 4; b++) begin
         acc(ACC_DIRECT, 1'b1, PROGRAM_STATUS_WORD_ADDR, 8'(b << 3));
         check_val(16'(bank), 16'(b));
         acc(ACC_REGISTER, 1'b0, 8'h00, 8'h00);
         check_val(16'(rdata), 16'(8'h40 + b));
      end
      acc(ACC_DIRECT, 1'b1, PROGRAM_STATUS_WORD_ADDR, 8'h00);
      acc(ACC_DIRECT, 1'b1, 8'h00, 8'h10);
      acc(ACC_DIRECT, 1'b1, 8'h10, 8'h5A);
      acc(ACC_INDIRECT, 1'b0, 8'h00, 8'h00);
      check_val(16'(rdata), 16'h005A);
      acc(ACC_DIRECT, 1'b1, 8'h01, 8'h90);
      acc(ACC_INDIRECT, 1'b1, 8'h01, 8'h77);
      acc(ACC_DIRECT, 1'b0, 8'h90, 8'h00);
      check_val({sfr_rd, ack, 6'h00, rdata}, 16'hC000);
      acc(ACC_INDIRECT, 1'b0, 8'h01, 8'h00);
      check_val(16'(rdata), 16'h0077);
      acc(ACC_DIRECT, 1'b1, 8'h22, 8'h00);
      acc(ACC_BIT, 1'b1, 8'h13, 8'h01);
      acc(ACC_DIRECT, 1'b0, 8'h22, 8'h00);
      check_val(16'(rdata), 16'h0008);
      acc(ACC_BIT, 1'b0, 8'h13, 8'h00);
      check_val(16'(bitr), 16'h0001);
      acc(ACC_BIT, 1'b1, 8'h93, 8'h01);
      check_val({sfr_wr, sbit, spbit, sbpos, 2'b00, sfr_addr}, 16'hEC90);
      check_val(16'(sfr_wd), 16'h0001);
      acc(ACC_DIRECT, 1'b1, STACK_TOP_POINTER_ADDR, 8'h30);
      stk(STK_PUSH);
      check_val(16'(sp), 16'h0031);
      acc(ACC_DIRECT, 1'b0, 8'h31, 8'h00);
      check_val({rdata, stop}, 16'hABAB);
      stk(STK_POP);
      check_val(16'(sp), 16'h0030);
      misc(1'b0, BR_RELATIVE, 16'h0000, 16'h0000, 8'hA5, 1'b0);
      check_val({btv, 7'h00, opx}, 16'h0000);
      misc(1'b1, BR_RELATIVE, 16'h1000, 16'h00F0, 8'h12, 1'b0);
      check_val(btgt, 16'h0FF0);
      check_val({btv, 7'h00, opx}, 16'h8012);
      misc(1'b1, BR_PAGE_LOCAL, 16'h3FFE, 16'h0123, 8'h00, 1'b0);
      check_val(btgt, 16'h3923);
      misc(1'b1, BR_LONG, 16'h0010, 16'hFEDC, 8'h00, 1'b0);
      check_val(btgt, 16'hFEDC);
      misc(1'b0, BR_RELATIVE, 16'h0000, 16'h0000, 8'h00, 1'b1);
      check_val(16'(pw), 16'h0000);
      acc(ACC_DIRECT, 1'b1, PROGRAM_STORE_CONTROL_ADDR, 8'h01);
      misc(1'b0, BR_RELATIVE, 16'h0000, 16'h0000, 8'h00, 1'b1);
      check_val({pw, 7'h00, pdata}, 16'h805C);
      check_val(paddr, 16'h1234);
      do_reset();
      repeat (16) stk(STK_CALL);
      check_val(16'(ovf), 16'h0000);
      stk(STK_CALL);
      check_val(16'(ovf), 16'h0001);
      do_reset();
      #1;
      check_val(16'({ovf, unf}), 16'h0000);
      stk(STK_POP);
      check_val(16'(unf), 16'h0001);
      tally_and_finish();
   end
endmodule // core_data_memory_organization_tb
